// ---- hw/tlbrl_top.sv ----
/*
 * TLB miss reload support: captures miss state, builds compare words
 * and group addresses, and merges the compare words into TLB loads.
 * Assumes a core that drops a miss request before it is taken and an APB
 * master that marks supervisor accesses with pprot[0].
 */
`timescale 1ns/1ps

module tlbrl_top
    import tlbrl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Miss request from the translation path
    input wire logic miss_req,
    input wire tlbrl_miss_s miss_info,
    input wire logic older_done,
    output logic miss_taken,
    // TLB load instruction
    input wire logic tlb_load,
    input wire logic tlb_load_instr,
    input wire logic [31:0] tlb_load_ea,
    output tlbrl_tlb_write_s tlb_wr
);

    typedef enum logic [1:0] {ST_IDLE, ST_DRAIN} tlbrl_state_e;

    tlbrl_state_e state_r, state_nxt;
    tlbrl_miss_s pend_r, pend_nxt;
    logic taken_r, taken_nxt;

    logic [31:0] dmiss_r, dmiss_nxt;
    logic [31:0] imiss_r, imiss_nxt;
    logic [31:0] data_miss_compare_word_r, data_miss_compare_word_nxt;
    logic [31:0] instr_miss_compare_word_r, instr_miss_compare_word_nxt;
    logic [31:0] pri_r, pri_nxt;
    logic [31:0] sec_r, sec_nxt;
    logic [31:0] phys_r, phys_nxt;
    logic [31:0] tbase_r, tbase_nxt;
    logic [2:0] saved_r, saved_nxt;
    tlbrl_tlb_write_s wr_r, wr_nxt;

    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic commit;
    logic setup;
    logic wr_ok;
    logic addr_hit;
    logic [31:0] rd_word;
    logic [31:0] grp_pri;
    logic [31:0] grp_sec;

    // Group addresses from the pending miss, formatted once
    tlbrl_group_addr u_group_addr (
        .origin(tbase_r[31:25]),
        .pri_hash(pend_r.pri_hash),
        .sec_hash(pend_r.sec_hash),
        .pri_addr(grp_pri),
        .sec_addr(grp_sec)
    );

    // Miss sequencing
    always_comb
    begin
        state_nxt = state_r;
        pend_nxt = pend_r;
        taken_nxt = 1'b0;
        commit = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                if (miss_req)
                begin
                    pend_nxt = miss_info;
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                // Older work must retire first
                if (older_done)
                begin
                    commit = 1'b1;
                    taken_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= ST_IDLE;
            pend_r <= '0;
            taken_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pend_r <= pend_nxt;
            taken_r <= taken_nxt;
        end
    end

    // APB decode; non-supervisor accesses are refused
    always_comb
    begin
        setup = psel && !penable;
        wr_ok = psel && penable && pready_r && pwrite && !pslverr_r;
        addr_hit = 1'b1;
        case (paddr)
            TLBRL_OFS_DATA_MISS: rd_word = dmiss_r;
            TLBRL_OFS_INSTR_MISS: rd_word = imiss_r;
            TLBRL_OFS_DATA_CMP: rd_word = data_miss_compare_word_r;
            TLBRL_OFS_INSTR_CMP: rd_word = instr_miss_compare_word_r;
            TLBRL_OFS_PRI_GROUP: rd_word = pri_r;
            TLBRL_OFS_SEC_GROUP: rd_word = sec_r;
            TLBRL_OFS_PHYS_ADDR: rd_word = phys_r;
            TLBRL_OFS_TABLE_BASE: rd_word = tbase_r;
            TLBRL_OFS_SAVED_STATE: rd_word = {29'h0, saved_r};
            default:
            begin
                rd_word = TLBRL_RESET_WORD;
                addr_hit = 1'b0;
            end
        endcase
        pready_nxt = setup;
        pslverr_nxt = setup && (!addr_hit || !pprot[0]);
        prdata_nxt = (setup && !pwrite && addr_hit && pprot[0]) ?
            rd_word : TLBRL_RESET_WORD;
    end

    // Register file; hardware capture wins over a same-cycle write
    always_comb
    begin
        dmiss_nxt = dmiss_r;
        imiss_nxt = imiss_r;
        data_miss_compare_word_nxt = data_miss_compare_word_r;
        instr_miss_compare_word_nxt = instr_miss_compare_word_r;
        pri_nxt = pri_r;
        sec_nxt = sec_r;
        phys_nxt = phys_r;
        tbase_nxt = tbase_r;
        saved_nxt = saved_r;
        if (wr_ok)
        begin
            case (paddr)
                TLBRL_OFS_DATA_MISS: dmiss_nxt = pwdata;
                TLBRL_OFS_INSTR_MISS: imiss_nxt = pwdata;
                TLBRL_OFS_DATA_CMP: data_miss_compare_word_nxt = pwdata;
                TLBRL_OFS_INSTR_CMP: instr_miss_compare_word_nxt = pwdata;
                // Reserved bits never stored
                TLBRL_OFS_PHYS_ADDR: phys_nxt = pwdata & TLBRL_PHYS_MASK;
                TLBRL_OFS_TABLE_BASE: tbase_nxt = pwdata;
                // Way and cause bits override by software
                TLBRL_OFS_SAVED_STATE: saved_nxt = pwdata[2:0];
                default:
                begin
                    saved_nxt = saved_r;
                end
            endcase
        end
        if (commit)
        begin
            if (pend_r.instr)
            begin
                imiss_nxt = pend_r.ea;
                instr_miss_compare_word_nxt = tlbrl_cmp_word(pend_r.virtual_segment_id, pend_r.ea);
            end
            else
            begin
                dmiss_nxt = pend_r.ea;
                data_miss_compare_word_nxt = tlbrl_cmp_word(pend_r.virtual_segment_id, pend_r.ea);
            end
            // Only hardware loads the group addresses: RO to software
            pri_nxt = grp_pri;
            sec_nxt = grp_sec;
            saved_nxt[TLBRL_SS_WAY_POS] = pend_r.lru_way;
            saved_nxt[TLBRL_SS_INSTR_POS] = pend_r.instr;
            saved_nxt[TLBRL_SS_LOAD_POS] = pend_r.load;
        end
    end

    // TLB load merge
    always_comb
    begin
        wr_nxt = '0;
        if (tlb_load)
        begin
            wr_nxt.valid = 1'b1;
            wr_nxt.instr = tlb_load_instr;
            wr_nxt.way = saved_r[TLBRL_SS_WAY_POS];
            wr_nxt.ea = tlb_load_ea;
            wr_nxt.word0 = tlb_load_instr ? instr_miss_compare_word_r : data_miss_compare_word_r;
            wr_nxt.word1 = phys_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dmiss_r <= TLBRL_RESET_WORD;
            imiss_r <= TLBRL_RESET_WORD;
            data_miss_compare_word_r <= TLBRL_RESET_WORD;
            instr_miss_compare_word_r <= TLBRL_RESET_WORD;
            pri_r <= TLBRL_RESET_WORD;
            sec_r <= TLBRL_RESET_WORD;
            phys_r <= TLBRL_RESET_WORD;
            tbase_r <= TLBRL_RESET_WORD;
            saved_r <= 3'h0;
            wr_r <= '0;
            prdata_r <= TLBRL_RESET_WORD;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            dmiss_r <= dmiss_nxt;
            imiss_r <= imiss_nxt;
            data_miss_compare_word_r <= data_miss_compare_word_nxt;
            instr_miss_compare_word_r <= instr_miss_compare_word_nxt;
            pri_r <= pri_nxt;
            sec_r <= sec_nxt;
            phys_r <= phys_nxt;
            tbase_r <= tbase_nxt;
            saved_r <= saved_nxt;
            wr_r <= wr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign miss_taken = taken_r;
    assign tlb_wr = wr_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_miss_accept;
        state_r == ST_IDLE && miss_req;
    endsequence

    sequence s_drain_done;
        state_r == ST_DRAIN && older_done;
    endsequence

    chk_taken_after_done: assert property (
        taken_r |-> $past(state_r) == ST_DRAIN && $past(older_done))
        else $error("miss taken before older work completed");

    chk_imiss_capture: assert property (
        s_drain_done ##0 pend_r.instr |=> imiss_r == $past(pend_r.ea))
        else $error("instruction miss address not captured");

    chk_dmiss_capture: assert property (
        s_drain_done ##0 !pend_r.instr |=> dmiss_r == $past(pend_r.ea)
            && instr_miss_compare_word_r == $past(instr_miss_compare_word_r))
        else $error("data miss used wrong register pair");

    chk_cmp_fields: assert property (
        s_miss_accept ##1 s_drain_done |=> taken_r &&
            (pend_r.instr ? instr_miss_compare_word_r[31] && !instr_miss_compare_word_r[6]
                          : data_miss_compare_word_r[31] && !data_miss_compare_word_r[6]))
        else $error("compare valid or hash id bit wrong");

    chk_cmp_virtual_segment_id_api: assert property (
        s_drain_done ##0 !pend_r.instr |=>
            data_miss_compare_word_r[30:7] == $past(pend_r.virtual_segment_id) &&
            data_miss_compare_word_r[5:0] == $past(pend_r.ea[27:22]))
        else $error("compare virtual_segment_id or page index wrong");

    chk_group_low_zero: assert property (
        pri_r[5:0] == 6'h00 && sec_r[5:0] == 6'h00 &&
        pri_r[31:25] == sec_r[31:25])
        else $error("group address low or origin bits wrong");

    chk_group_ro: assert property (
        !commit |=> pri_r == $past(pri_r) && sec_r == $past(sec_r))
        else $error("group address changed without a miss");

    chk_phys_reserved: assert property (
        (phys_r & ~TLBRL_PHYS_MASK) == 32'h00000000)
        else $error("physical register reserved bits set");

    chk_tlb_merge: assert property (
        tlb_load && tlb_load_instr |=> tlb_wr.valid &&
            tlb_wr.word0 == $past(instr_miss_compare_word_r) && tlb_wr.word1 == $past(phys_r)
            && tlb_wr.way == $past(saved_r[0]))
        else $error("tlb load merge wrong");

    chk_user_refused: assert property (
        psel && !penable && !pprot[0] |=> pready && pslverr
            && prdata == 32'h00000000)
        else $error("user access not refused");

endmodule : tlbrl_top

// ---- hw/tlbrl_pkg.sv ----
/*
 * Package for the TLB miss reload support block: register offsets,
 * field positions, reset values and the carrier structs.
 * Assumes a 32-bit APB register bus and big-endian bit numbering
 * in the field comments (bit 0 is the most significant bit).
 */
package tlbrl_pkg;

    // Register byte offsets on the APB window
    localparam logic [7:0] TLBRL_OFS_DATA_MISS = 8'h00;
    localparam logic [7:0] TLBRL_OFS_INSTR_MISS = 8'h04;
    localparam logic [7:0] TLBRL_OFS_DATA_CMP = 8'h08;
    localparam logic [7:0] TLBRL_OFS_INSTR_CMP = 8'h0C;
    localparam logic [7:0] TLBRL_OFS_PRI_GROUP = 8'h10;
    localparam logic [7:0] TLBRL_OFS_SEC_GROUP = 8'h14;
    localparam logic [7:0] TLBRL_OFS_PHYS_ADDR = 8'h18;
    localparam logic [7:0] TLBRL_OFS_TABLE_BASE = 8'h1C;
    localparam logic [7:0] TLBRL_OFS_SAVED_STATE = 8'h20;

    // Compare word fields (bit 0 = [31])
    localparam int TLBRL_CMP_VALID_POS = 31;
    localparam int TLBRL_CMP_VIRTUAL_SEGMENT_ID_LSB = 7;
    localparam int TLBRL_CMP_HASH_ID_POS = 6;
    localparam int TLBRL_CMP_API_LSB = 0;
    // Abbreviated page index inside the effective address
    localparam int TLBRL_EA_API_LSB = 22;
    // Group address fields
    localparam int TLBRL_GRP_ORIGIN_LSB = 25;
    localparam int TLBRL_GRP_HASHED_LSB = 6;
    // Physical address register: reserved bits read as zero
    localparam logic [31:0] TLBRL_PHYS_MASK = 32'hFFFFF1FB;
    // Saved state word bits held here, low-bit order
    localparam int TLBRL_SS_WAY_POS = 0;
    localparam int TLBRL_SS_INSTR_POS = 1;
    localparam int TLBRL_SS_LOAD_POS = 2;
    localparam logic [31:0] TLBRL_RESET_WORD = 32'h00000000;

    typedef struct packed {
        logic instr;
        logic load;
        logic [31:0] ea;
        logic [23:0] virtual_segment_id;
        logic lru_way;
        logic [18:0] pri_hash;
        logic [18:0] sec_hash;
    } tlbrl_miss_s;

    typedef struct packed {
        logic valid;
        logic instr;
        logic way;
        logic [31:0] ea;
        logic [31:0] word0;
        logic [31:0] word1;
    } tlbrl_tlb_write_s;

    // Compare word for a freshly missed access
    function automatic logic [31:0] tlbrl_cmp_word(
        input logic [23:0] virtual_segment_id,
        input logic [31:0] ea
    );
        logic [31:0] w;
        w = TLBRL_RESET_WORD;
        w[TLBRL_CMP_VALID_POS] = 1'b1;
        w[TLBRL_CMP_VIRTUAL_SEGMENT_ID_LSB +: 24] = virtual_segment_id;
        w[TLBRL_CMP_HASH_ID_POS] = 1'b0;
        w[TLBRL_CMP_API_LSB +: 6] = ea[TLBRL_EA_API_LSB +: 6];
        return w;
    endfunction : tlbrl_cmp_word

endpackage : tlbrl_pkg

// ---- hw/tlbrl_group_addr.sv ----
/*
 * Formats the primary and secondary page table group addresses from
 * the table origin and the hashed bits computed elsewhere in the MMU.
 * Assumes the hashed bits belong to the captured miss address.
 */
`timescale 1ns/1ps
module tlbrl_group_addr
    import tlbrl_pkg::*;
(
    // Table origin, upper seven bits
    input wire logic [6:0] origin,
    // Hashed group bits
    input wire logic [18:0] pri_hash,
    input wire logic [18:0] sec_hash,
    // Formatted addresses
    output logic [31:0] pri_addr,
    output logic [31:0] sec_addr
);

    function automatic logic [31:0] tlbrl_fmt(
        input logic [6:0] org,
        input logic [18:0] hashed
    );
        logic [31:0] w;
        w = TLBRL_RESET_WORD;
        w[TLBRL_GRP_ORIGIN_LSB +: 7] = org;
        w[TLBRL_GRP_HASHED_LSB +: 19] = hashed;
        return w;
    endfunction : tlbrl_fmt

    always_comb
    begin
        pri_addr = tlbrl_fmt(origin, pri_hash);
        sec_addr = tlbrl_fmt(origin, sec_hash);
    end

endmodule : tlbrl_group_addr

// ---- verification/tlb_miss_reload_support_tb.sv ----
/*
 * Self-checking bench for tlbrl_top: register access, miss capture,
 * compare and group words, TLB load merge.
 * Assumes the package offsets and the hand-over timing of the design.
 */
`timescale 1ns/1ps
module tlb_miss_reload_support_tb
    import tlbrl_pkg::*;
;
    localparam logic [31:0] PHYS_KEEP = 32'hFFFFF1FB;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [2:0] pprot = 3'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic miss_req = 1'b0;
    tlbrl_miss_s miss_info = '0;
    logic older_done = 1'b0;
    logic miss_taken;
    logic tlb_load = 1'b0;
    logic tlb_load_instr = 1'b0;
    logic [31:0] tlb_load_ea = 32'h00000000;
    tlbrl_tlb_write_s tlb_wr;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h2DADA1A4;
    logic [31:0] mdl [0:8];
    logic [33:0] rd_q [$];
    tlbrl_tlb_write_s wr_q [$];

    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    tlbrl_top i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .miss_req(miss_req), .miss_info(miss_info),
        .older_done(older_done), .miss_taken(miss_taken),
        .tlb_load(tlb_load), .tlb_load_instr(tlb_load_instr),
        .tlb_load_ea(tlb_load_ea), .tlb_wr(tlb_wr)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [98:0] seen, input logic [98:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [2:0] pr,
                       input logic [33:0] e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pprot <= pr;
        rd_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        check(99'(pready), 99'(0));
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check(99'(pready), 99'(1));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Upper protection bits random: only the privilege bit may matter
    task automatic rd(input logic [7:0] a, input logic priv);
        logic [31:0] r;
        logic err;
        r = rnd();
        err = !priv || (a > TLBRL_OFS_SAVED_STATE);
        apb(1'b0, a, r, {r[2:1], priv},
            {1'b1, err, err ? 32'h00000000 : mdl[a[5:2]]});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic priv);
        logic [31:0] r;
        logic err;
        r = rnd();
        err = !priv || (a > TLBRL_OFS_SAVED_STATE);
        apb(1'b1, a, d, {r[2:1], priv}, {2'b00, err, 32'h00000000});
        if (!err && a == TLBRL_OFS_PHYS_ADDR)
            mdl[6] = d & PHYS_KEEP;
        if (!err && a == TLBRL_OFS_SAVED_STATE)
            mdl[8] = {29'h00000000, d[2:0]};
        if (!err && a == TLBRL_OFS_TABLE_BASE)
            mdl[7] = d;
    endtask : wr

    task automatic rd_all();
        for (int k = 0; k < 9; k++)
            rd(8'(k * 4), 1'b1);
    endtask : rd_all

    task automatic miss(input logic side, input logic fast);
        tlbrl_miss_s m;
        logic [31:0] r;
        int n;
        r = rnd();
        m.instr = side;
        m.load = !side & r[0];
        m.lru_way = r[1];
        m.virtual_segment_id = r[31:8];
        m.ea = rnd();
        r = rnd();
        m.pri_hash = r[18:0];
        m.sec_hash = r[31:13];
        @(posedge pclk);
        miss_req <= 1'b1;
        miss_info <= m;
        // Fast case: older work already retired, shortest path
        older_done <= fast;
        repeat (fast ? 1 : 5)
        begin
            @(posedge pclk);
            check(99'(miss_taken), 99'(0));
        end
        // Drop the request with the drain so no second miss is accepted
        older_done <= 1'b1;
        miss_req <= 1'b0;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (miss_taken !== 1'b1 && n < 10);
        check(99'(miss_taken), 99'(1));
        check(99'(n), 99'(2));
        older_done <= 1'b0;
        mdl[side ? 1 : 0] = m.ea;
        mdl[side ? 3 : 2] = {1'b1, m.virtual_segment_id, 1'b0, m.ea[27:22]};
        mdl[4] = {mdl[7][31:25], m.pri_hash, 6'h00};
        mdl[5] = {mdl[7][31:25], m.sec_hash, 6'h00};
        mdl[8] = {29'h00000000, m.load, side, m.lru_way};
    endtask : miss

    task automatic tload(input logic side, input logic [31:0] ea);
        tlbrl_tlb_write_s w;
        w.valid = 1'b1;
        w.instr = side;
        w.way = mdl[8][0];
        w.ea = ea;
        w.word0 = mdl[side ? 3 : 2];
        w.word1 = mdl[6];
        wr_q.push_back(w);
        tlb_load <= 1'b1;
        tlb_load_instr <= side;
        tlb_load_ea <= ea;
    endtask : tload

    always @(posedge pclk)
    begin
        logic [33:0] e;
        if (psel && penable && pready && rd_q.size() > 0)
        begin
            e = rd_q.pop_front();
            check(99'(pslverr), 99'(e[32]));
            if (e[33])
                check(99'(prdata), 99'(e[31:0]));
        end
        if (tlb_wr.valid === 1'b1)
            check(99'(tlb_wr), 99'(wr_q.size() > 0 ? wr_q.pop_front() : '0));
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        for (int k = 0; k < 9; k++)
            mdl[k] = 32'h00000000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_all();
        $display("Test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            wr(TLBRL_OFS_TABLE_BASE, rnd(), 1'b1);
            miss(i[0], i[1]);
            rd_all();
            // Store data misses come with the change bit already set
            wr(TLBRL_OFS_PHYS_ADDR,
               rnd() | {24'h000000, (mdl[8][2:1] == 2'b00), 7'h00},
               1'b1);
            // Software rewrites the cause bits and the way bit, as fault setup would
            if (i == 1)
                wr(TLBRL_OFS_SAVED_STATE, mdl[8] | 32'h4, 1'b1);
            if (i == 2)
                wr(TLBRL_OFS_SAVED_STATE, mdl[8] & 32'h1, 1'b1);
            if (i == 3)
                wr(TLBRL_OFS_SAVED_STATE, mdl[8] ^ 32'h1, 1'b1);
            rd(TLBRL_OFS_SAVED_STATE, 1'b1);
            @(posedge pclk);
            tload(1'b1, rnd());
            @(posedge pclk);
            tload(1'b0, rnd());
            @(posedge pclk);
            tlb_load <= 1'b0;
            $display("Test miss and load %0d done", i);
        end
        wr(TLBRL_OFS_PHYS_ADDR, rnd(), 1'b0);
        rd(TLBRL_OFS_PHYS_ADDR, 1'b0);
        wr(TLBRL_OFS_PRI_GROUP, rnd(), 1'b1);
        wr(TLBRL_OFS_SEC_GROUP, rnd(), 1'b1);
        wr(8'h24, rnd(), 1'b1);
        rd(8'h24, 1'b1);
        rd_all();
        $display("Test refused accesses done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 9; k++)
            mdl[k] = 32'h00000000;
        rd_all();
        $display("Test mid-run reset done");
        repeat (4) @(posedge pclk);
        check(99'(rd_q.size() + wr_q.size()), 99'(0));
        report_and_stop();
    end

endmodule : tlb_miss_reload_support_tb
